// ==== common/mem_err_defs.svh ====
/*
  constants for the memory write sequencer and error status capture.
  assumes one clock domain and a single status register word.
*/
// Function
// R1: unmasked cpu write acked before parity, ecc, write
// R2: unmasked dma write: no parity check, ack, write
// R3: masked write: read, check, merge, ack, rewrite
// R4: multiword dma: ack each word, end after last
// R5: uncorrectable error sets bit 31
// R6: repeat uncorrectable error sets bit 30
// R7: correctable error sets bit 29
// R8: ecc flags undefined while bit 7 set
// R9: error flags clear by writing one
// R10: bits 28:9 hold failing page, read only
// R11: page holds highest priority error
// R12: equal priority error never overwrites capture
// R13: priority: parity, uncorrectable, correctable
// R14: dma read or write error sets bit 8
// R15: cpu write parity error sets bit 7
// R16: bits 6:0 hold syndrome, read only
// R17: unknown nonzero syndrome means uncorrectable
// R18: syndrome follows page capture priority
// R19: zero syndrome means no error; data codes
// R20: power-up or dc_power_ok drop while halted clears
// R21: check bit codes one-hot, remaining data codes
// R22: parity error stores bad check bits, 0000111
// R23: mode bit 10 disables detection and capture
// R24: late parity error still flagged and captured
`ifndef MEM_ERR_DEFS_SVH
`define MEM_ERR_DEFS_SVH

`define MES_ADDR    32'h1008_0140
`define UE_BIT      31
`define HER_BIT     30
`define CE_BIT      29
`define PAGE_HI     28
`define PAGE_LO     9
`define DMA_BIT     8
`define PE_BIT      7
`define SYN_W       7
`define SYN_NONE    7'h00
`define SYN_PARITY  7'h07
`define PARITY_ODD  1'b1
`define MASK_FULL   4'hf
`define CHK_W       7
`define DATA_W      32

// syndrome per data bit, bit 31 first
`define ECC_CODES { \
  7'b1111001, 7'b0111101, 7'b0111011, 7'b1111111, \
  7'b0111110, 7'b1111010, 7'b1111100, 7'b0111000, \
  7'b0110001, 7'b1110101, 7'b1110011, 7'b0110111, \
  7'b1110110, 7'b0110010, 7'b0110100, 7'b1110000, \
  7'b0101001, 7'b1101101, 7'b1101011, 7'b0101111, \
  7'b1101110, 7'b0101010, 7'b0101100, 7'b1101000, \
  7'b0011001, 7'b1011101, 7'b1011011, 7'b0011111, \
  7'b1011110, 7'b0011010, 7'b0011100, 7'b1011000}

`endif

// ==== common/mem_err_pkg.sv ====
/*
  types and small decoders shared by the write sequencer.
  assumes mem_err_defs.svh is on the include path.
*/
`default_nettype none
`include "mem_err_defs.svh"
package mem_err_pkg;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_WRITE    = 2'b01,
    ST_RMW_READ = 2'b10
  } wr_state_e;

  typedef struct packed {
    logic        dma;
    logic        last;
    logic [3:0]  mask;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  par;
  } wr_req_s;

  typedef struct packed {
    logic        valid;
    logic        dma;
    logic [31:0] addr;
    logic [38:0] word;
  } rd_chk_s;

  typedef struct packed {
    logic        pe;
    logic        ue;
    logic        ce;
    logic        dma;
    logic [19:0] page;
    logic [6:0]  syn;
  } err_ev_s;

  // only enabled byte lanes are checked
  function automatic logic bad_parity(input logic [31:0] d, input logic [3:0] p,
                                      input logic [3:0] m);
    logic bad;
    bad = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (m[b] && ((^d[8*b +: 8] ^ p[b]) != `PARITY_ODD)) begin
        bad = 1'b1;
      end
    end
    return bad;
  endfunction : bad_parity

  function automatic logic [1:0] err_prio(input logic pe, input logic ue, input logic ce);
    if (pe) begin
      return 2'h3;
    end else if (ue) begin
      return 2'h2;
    end else if (ce) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction : err_prio

endpackage : mem_err_pkg
`default_nettype wire

// ==== logic/ecc_syndrome.sv ====
/*
  check bit generator and syndrome decoder for a 32+7 bit word.
  purely combinational; caller registers what it needs.
*/
`default_nettype none
`include "mem_err_defs.svh"
module ecc_syndrome import mem_err_pkg::*; #(
  parameter int unsigned DATA_W = `DATA_W,
  parameter int unsigned CHK_W  = `CHK_W
) (
  // word in
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic [CHK_W-1:0]  check_i,
  // results
  output logic      [CHK_W-1:0]  gen_o,
  output logic      [CHK_W-1:0]  syn_o,
  output logic      [DATA_W-1:0] fixed_o,
  output logic                   single_o,
  output logic                   multi_o
);
  localparam logic [223:0] CODES = `ECC_CODES;

  // code table is fixed to this geometry
  if (DATA_W != 32 || CHK_W != 7) begin : g_bad
    $error("ecc_syndrome supports only 32 data and 7 check bits");
  end

  logic [DATA_W-1:0] hit;

  for (genvar j = 0; j < CHK_W; j++) begin : g_chk
    logic [DATA_W-1:0] sel;
    for (genvar i = 0; i < DATA_W; i++) begin : g_sel
      assign sel[i] = CODES[CHK_W*i + j];
    end
    assign gen_o[j] = ^(data_i & sel);
  end

  assign syn_o = gen_o ^ check_i; // R19 R21
  for (genvar i = 0; i < DATA_W; i++) begin : g_hit
    assign hit[i] = (syn_o == CODES[CHK_W*i +: CHK_W]); // R16
  end

  assign fixed_o  = data_i ^ hit;
  assign single_o = (|hit) | $onehot(syn_o); // R21
  assign multi_o  = (syn_o != `SYN_NONE) && !single_o; // R17
endmodule : ecc_syndrome
`default_nettype wire

// ==== logic/mem_write_ecc_capture.sv ====
/*
  write path sequencer and error status capture of the memory controller.
  assumes requests and memory handshakes are on clock_i; power and halt
  levels arrive from pins and are synchronised here.
*/
`default_nettype none
`include "mem_err_defs.svh"
module mem_write_ecc_capture import mem_err_pkg::*; (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // shared bus write request
  input  wire logic        req_valid_i,
  input  wire wr_req_s     req_i,
  output logic             req_ready_o,
  output logic             word_ack_o,
  output logic             bus_done_o,
  // read results checked by this block
  input  wire rd_chk_s     rd_i,
  // memory array
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic [31:0]      mem_addr_o,
  output logic [38:0]      mem_wdata_o,
  input  wire logic        mem_rvalid_i,
  input  wire logic [38:0] mem_rdata_i,
  // status register access
  input  wire logic        csr_wr_i,
  input  wire logic        csr_rd_i,
  input  wire logic [31:0] csr_addr_i,
  input  wire logic [31:0] csr_wdata_i,
  output logic [31:0]      csr_rdata_o,
  // mode and system levels
  input  wire logic        ecc_disable_i,
  input  wire logic        dc_power_ok_i,
  input  wire logic        halted_i
);

  wr_state_e   state_q;
  wr_req_s     req_q;
  logic        rmw_q;
  logic [31:0] wdata_q;
  logic        mem_rd_q;
  logic        mem_wr_q;
  logic [38:0] mem_wdata_q;
  logic [31:0] csr_rdata_q;
  logic [1:0]  dc_power_ok_q;
  logic [1:0]  halt_q;
  logic        ue_q, her_q, ce_q, dma_q, pe_q;
  logic [19:0] page_q;
  logic [6:0]  syn_q;

  logic        accept, full;
  logic        par_err;
  logic        clr_all;
  logic        csr_hit;
  logic [31:0] wclr;
  logic [31:0] status;
  logic [6:0]  gen_chk;
  logic [6:0]  rmw_syn, rd_syn;
  logic [31:0] rmw_fixed;
  logic        rmw_single, rmw_multi, rd_single, rd_multi;
  err_ev_s     wev, rev, best;
  logic        capture;

  // pin levels: second stage only is read
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dc_power_ok_q <= 2'h0;
      halt_q <= 2'h0;
    end else begin
      dc_power_ok_q <= {dc_power_ok_q[0], dc_power_ok_i};
      halt_q <= {halt_q[0], halted_i};
    end
  end

  assign clr_all = !dc_power_ok_q[1] && halt_q[1]; // R20

  // ---------------- write sequencing ----------------
  assign req_ready_o = (state_q == ST_IDLE);
  assign accept      = req_valid_i && req_ready_o;
  assign full        = (req_i.mask == `MASK_FULL);

  // unmasked: ack on latch; masked: ack once merged check bits are ready
  assign word_ack_o  = (accept && full) // R1 R2
                    || (state_q == ST_WRITE && rmw_q); // R3
  assign bus_done_o  = word_ack_o &&
                       (accept ? (!req_i.dma || req_i.last)
                               : (!req_q.dma || req_q.last)); // R4

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      req_q   <= '0;
      rmw_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            req_q   <= req_i;
            rmw_q   <= !full;
            state_q <= full ? ST_WRITE : ST_RMW_READ; // R1 R2 R3
          end
        end
        ST_RMW_READ: begin
          if (mem_rvalid_i) begin
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          rmw_q   <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // data to write: bus word, or old word corrected and merged
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdata_q <= 32'h0;
    end else if (accept) begin
      wdata_q <= req_i.data;
    end else if (state_q == ST_RMW_READ && mem_rvalid_i) begin
      for (int b = 0; b < 4; b++) begin
        wdata_q[8*b +: 8] <= req_q.mask[b] ? req_q.data[8*b +: 8]
                           : (ecc_disable_i ? mem_rdata_i[8*b +: 8]
                                            : rmw_fixed[8*b +: 8]); // R3 R23
      end
    end
  end

  ecc_syndrome u_gen (
    .data_i   (wdata_q),
    .check_i  (7'h00),
    .gen_o    (gen_chk),
    .syn_o    (),
    .fixed_o  (),
    .single_o (),
    .multi_o  ()
  );

  ecc_syndrome u_rmw (
    .data_i   (mem_rdata_i[31:0]),
    .check_i  (mem_rdata_i[38:32]),
    .gen_o    (),
    .syn_o    (rmw_syn),
    .fixed_o  (rmw_fixed),
    .single_o (rmw_single),
    .multi_o  (rmw_multi)
  );

  ecc_syndrome u_rd (
    .data_i   (rd_i.word[31:0]),
    .check_i  (rd_i.word[38:32]),
    .gen_o    (),
    .syn_o    (rd_syn),
    .fixed_o  (),
    .single_o (rd_single),
    .multi_o  (rd_multi)
  );

  // parity is judged in ST_WRITE: after the ack of an unmasked write, in the same cycle as the ack of a masked one
  assign par_err = (state_q == ST_WRITE) && !req_q.dma
                && bad_parity(req_q.data, req_q.par, req_q.mask); // R1 R2 R24

  // memory strobes and write word
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= 39'h0;
    end else begin
      mem_rd_q <= accept && !full; // R3
      mem_wr_q <= (state_q == ST_WRITE);
      if (state_q == ST_WRITE) begin
        mem_wdata_q <= {gen_chk ^ (wev.pe ? `SYN_PARITY : `SYN_NONE), wdata_q}; // R22
      end
    end
  end

  assign mem_rd_o    = mem_rd_q;
  assign mem_wr_o    = mem_wr_q;
  assign mem_addr_o  = req_q.addr;
  assign mem_wdata_o = mem_wdata_q;

  // ---------------- error events ----------------
  always_comb begin
    wev      = '0;
    wev.page = req_q.addr[`PAGE_HI:`PAGE_LO];
    if (!ecc_disable_i) begin // R23
      if (par_err) begin
        wev.pe  = 1'b1; // R15 R24
        wev.syn = `SYN_PARITY;
      end else if (state_q == ST_RMW_READ && mem_rvalid_i) begin
        wev.ue  = rmw_multi; // R5 R17
        wev.ce  = rmw_single; // R7
        wev.dma = req_q.dma && (rmw_multi || rmw_single); // R14
        wev.syn = rmw_syn; // R16
      end
    end
  end

  always_comb begin
    rev      = '0;
    rev.page = rd_i.addr[`PAGE_HI:`PAGE_LO];
    if (!ecc_disable_i && rd_i.valid) begin // R23
      rev.ue  = rd_multi; // R5 R17
      rev.ce  = rd_single; // R7
      rev.dma = rd_i.dma && (rd_multi || rd_single); // R14
      rev.syn = rd_syn;
    end
  end

  assign best = (err_prio(rev.pe, rev.ue, rev.ce) > err_prio(wev.pe, wev.ue, wev.ce))
              ? rev : wev; // R13

  // ---------------- status register ----------------
  assign csr_hit = (csr_addr_i == `MES_ADDR);
  assign wclr    = (csr_wr_i && csr_hit) ? csr_wdata_i : 32'h0;

  // strictly higher priority than what is still flagged replaces it
  assign capture = err_prio(best.pe, best.ue, best.ce) >
                   err_prio(pe_q && !wclr[`PE_BIT], ue_q && !wclr[`UE_BIT],
                            ce_q && !wclr[`CE_BIT]); // R11 R12 R13

  // set wins over a same-cycle write-one clear
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ue_q  <= 1'b0;
      her_q <= 1'b0;
      ce_q  <= 1'b0;
      dma_q <= 1'b0;
      pe_q  <= 1'b0;
    end else if (clr_all) begin // R20
      ue_q  <= 1'b0;
      her_q <= 1'b0;
      ce_q  <= 1'b0;
      dma_q <= 1'b0;
      pe_q  <= 1'b0;
    end else begin
      ue_q  <= (ue_q && !wclr[`UE_BIT]) || wev.ue || rev.ue; // R5 R9
      her_q <= (her_q && !wclr[`HER_BIT]) || (ue_q && (wev.ue || rev.ue)); // R6 R9
      ce_q  <= (ce_q && !wclr[`CE_BIT]) || wev.ce || rev.ce; // R7 R9
      dma_q <= (dma_q && !wclr[`DMA_BIT]) || wev.dma || rev.dma; // R14 R9
      pe_q  <= (pe_q && !wclr[`PE_BIT]) || wev.pe; // R15 R9
    end
  end

  // page and syndrome ignore writes
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      page_q <= 20'h0;
      syn_q  <= 7'h00;
    end else if (clr_all) begin // R20
      page_q <= 20'h0;
      syn_q  <= 7'h00;
    end else if (capture) begin
      page_q <= best.page; // R10 R11
      syn_q  <= best.syn; // R16 R18
    end
  end

  // ecc flags carry no meaning while pe_q is set; her_q update and status still read them then
  assign status = {ue_q, her_q, ce_q, page_q, dma_q, pe_q, syn_q}; // R8 R10 R16

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      csr_rdata_q <= 32'h0;
    end else if (csr_rd_i) begin
      csr_rdata_q <= csr_hit ? status : 32'h0;
    end
  end

  assign csr_rdata_o = csr_rdata_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_latched_write;
    (state_q == ST_WRITE) ##1 mem_wr_o;
  endsequence

  sequence s_merged_write;
    (state_q == ST_WRITE && word_ack_o) ##1 (mem_wr_o && !(word_ack_o && !accept));
  endsequence

  a_unmasked_dump_run: assert property ( // R1
    (accept && full && !req_i.dma) |-> word_ack_o ##1 s_latched_write)
    else $error("unmasked cpu write not acked before memory write");

  a_dma_no_parity: assert property ( // R2
    (state_q == ST_WRITE && req_q.dma) |-> !wev.pe)
    else $error("parity judged on a dma write");

  a_rmw_order: assert property ( // R3
    (accept && !full) |=> mem_rd_o && !word_ack_o)
    else $error("masked write acked before old word read");

  a_rmw_ack_write: assert property ( // R3
    (state_q == ST_RMW_READ && mem_rvalid_i) |=> s_merged_write)
    else $error("merged word not acked then written");

  a_multi_done: assert property ( // R4
    (word_ack_o && !accept && req_q.dma && !req_q.last) |-> !bus_done_o)
    else $error("dma transaction ended before last word");

  a_ue_flag: assert property ( // R5
    (wev.ue || rev.ue) && !clr_all |=> ue_q)
    else $error("uncorrectable error not flagged");

  a_her_flag: assert property ( // R6
    (ue_q && rev.ue && !clr_all) |=> her_q)
    else $error("repeat uncorrectable error not flagged");

  a_w1c_clear: assert property ( // R9
    (wclr[`CE_BIT] && !wev.ce && !rev.ce && ce_q) |=> !ce_q)
    else $error("write one did not clear correctable flag");

  a_page_keep: assert property ( // R12
    (pe_q && wev.pe && !wclr[`PE_BIT] && !clr_all) |=> $stable(page_q))
    else $error("equal priority error overwrote page");

  a_parity_capture: assert property ( // R15
    (wev.pe && !pe_q && !clr_all) |=> pe_q && (page_q == $past(wev.page))
                                        && (syn_q == `SYN_PARITY))
    else $error("parity error not captured");

  a_bad_check: assert property ( // R22
    (state_q == ST_WRITE && wev.pe) |=>
      mem_wdata_o[38:32] == ($past(gen_chk) ^ `SYN_PARITY))
    else $error("bad check bits not stored on parity error");

  a_disable_quiet: assert property ( // R23
    ecc_disable_i |=> $stable(page_q) || $past(clr_all))
    else $error("capture while detection disabled");

  a_power_clear: assert property ( // R20
    clr_all |=> (status == 32'h0))
    else $error("status not cleared on power drop while halted");

endmodule : mem_write_ecc_capture
`default_nettype wire

// ==== tb/mem_model.sv ====
/*
  memory array model standing behind the write sequencer.
  assumes the sequencer clock; answers reads promptly or slowly.
*/
`default_nettype none
module mem_model (
  // clock
  input  wire logic        clock_i,
  // requests from the sequencer, speed select from the bench
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [38:0] mem_wdata_i,
  input  wire logic        slow_i,
  // read answer
  output logic             mem_rvalid_o,
  output logic [38:0]      mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [38:0] mem [logic [31:0]];
  logic [2:0]  cnt_q = 3'h0;
  logic        pend_q = 1'b0;
  logic [31:0] a_q = 32'h0;
  initial begin
    mem_rvalid_o = 1'b0;
    mem_rdata_o  = 39'h0;
  end
  // idle data toggles so a stale word never passes for an answer
  always @(posedge clock_i) begin
    mem_rvalid_o <= 1'b0;
    mem_rdata_o  <= ~mem_rdata_o;
    if (mem_wr_i) begin
      mem[mem_addr_i] = mem_wdata_i;
    end
    if (mem_rd_i) begin
      pend_q <= 1'b1;
      cnt_q  <= slow_i ? 3'h4 : 3'h0;
      a_q    <= mem_addr_i;
    end else if (pend_q && cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end else if (pend_q) begin
      pend_q       <= 1'b0;
      mem_rvalid_o <= 1'b1;
      mem_rdata_o  <= mem.exists(a_q) ? mem[a_q] : 39'h0;
    end
  end
  task automatic flip(input logic [31:0] a, input logic [38:0] m);
    mem[a] = mem[a] ^ m;
  endtask : flip
endmodule : mem_model
`default_nettype wire

// ==== tb/tb.sv ====
/*
  self-checking bench for the write sequencer and error capture.
  assumes mem_model as the memory behind the block.
*/
`default_nettype none
`include "mem_err_defs.svh"
module tb import mem_err_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [223:0] CODES = `ECC_CODES;
  localparam logic [31:0]  CLR   = 32'he000_0180;
  logic        clock_i, rstn_i, req_valid_i, req_ready_o, word_ack_o, bus_done_o;
  logic        mem_rd_o, mem_wr_o, mem_rvalid_i, csr_wr_i, csr_rd_i, slow;
  logic        ecc_disable_i, dc_power_ok_i, halted_i, done;
  wr_req_s     req_i;
  rd_chk_s     rd_i;
  logic [31:0] mem_addr_o, csr_addr_i, csr_wdata_i, csr_rdata_o, st, d, d2, a, p1, p2, p3;
  logic [38:0] mem_wdata_o, mem_rdata_i, w;
  int          err_total, num_checks, lat, k;
  int          cyc = 0;

  mem_write_ecc_capture i_mem_write_ecc_capture (.clock_i, .rstn_i, .req_valid_i, .req_i,
    .req_ready_o, .word_ack_o, .bus_done_o, .rd_i, .mem_rd_o, .mem_wr_o, .mem_addr_o,
    .mem_wdata_o, .mem_rvalid_i, .mem_rdata_i, .csr_wr_i, .csr_rd_i, .csr_addr_i,
    .csr_wdata_i, .csr_rdata_o, .ecc_disable_i, .dc_power_ok_i, .halted_i);
  mem_model i_mem_model (.clock_i, .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .slow_i(slow),
    .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));

  function automatic logic [6:0] gen(input logic [31:0] x);
    logic [6:0] c;
    c = 7'h0;
    for (int i = 0; i < 32; i++) begin
      if (x[i]) begin
        c ^= CODES[7*i +: 7];
      end
    end
    return c;
  endfunction : gen
  function automatic logic [6:0] syn_of(input int b);
    return (b < 32) ? CODES[7*b +: 7] : 7'(1 << (b - 32));
  endfunction : syn_of
  function automatic logic [31:0] stat(input logic [2:0] f, input logic [31:0] pa,
                                       input logic dm, input logic pe, input logic [6:0] s);
    return {f, pa[28:9], dm, pe, s};
  endfunction : stat
  function automatic logic [3:0] par(input logic [31:0] x);
    for (int b = 0; b < 4; b++) begin
      par[b] = ~^x[8*b +: 8];
    end
  endfunction : par

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic csr_w(input logic [31:0] x);
    csr_addr_i = `MES_ADDR;
    csr_wdata_i = x;
    csr_wr_i = 1'b1;
    @(posedge clock_i);
    #1 csr_wr_i = 1'b0;
    @(posedge clock_i);
    #1;
  endtask : csr_w
  task automatic csr_r(input logic [31:0] ad, output logic [31:0] x);
    csr_addr_i = ad;
    csr_rd_i = 1'b1;
    @(posedge clock_i);
    #1 csr_rd_i = 1'b0;
    x = csr_rdata_o;
    @(posedge clock_i);
    #1;
  endtask : csr_r
  task automatic st_is(input logic [31:0] e);
    csr_r(`MES_ADDR, st);
    // ecc flags mean nothing while the parity flag stands
    chk(st & {{3{!e[`PE_BIT]}}, 29'h1fff_ffff}, e & {{3{!e[`PE_BIT]}}, 29'h1fff_ffff});
  endtask : st_is
  task automatic rd_chk(input logic [38:0] wd, input logic [31:0] ad, input logic dm);
    rd_i = {1'b1, dm, ad, wd};
    @(posedge clock_i);
    #1 rd_i.valid = 1'b0;
    @(posedge clock_i);
    #1;
  endtask : rd_chk
  // held until the take edge; ack seen just before each edge
  task automatic wr(input logic dm, input logic lst, input logic [3:0] m,
                    input logic [31:0] ad, input logic [31:0] x, input logic bad);
    req_i = {dm, lst, m, ad, x, par(x) ^ {3'h0, bad}};
    req_valid_i = 1'b1;
    lat = -1;
    done = 1'b0;
    for (int n = 0; n < 30 && lat < 0; n++) begin
      #8;
      if (word_ack_o === 1'b1) begin
        lat = n;
        done = bus_done_o;
      end
      @(posedge clock_i);
      #1 req_valid_i = 1'b0;
      if (n == 0) begin
        chk(req_ready_o, 1'b0);
      end
    end
    repeat (3) @(posedge clock_i);
    #1;
  endtask : wr

  always #5 clock_i = ~clock_i;
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    {clock_i, rstn_i, req_valid_i, csr_wr_i, csr_rd_i, slow, ecc_disable_i, halted_i} = '0;
    dc_power_ok_i = 1'b1;
    req_i = '0;
    rd_i = '0;
    csr_addr_i = 32'h0;
    csr_wdata_i = 32'h0;
    err_total = 0;
    num_checks = 0;
    k = $urandom(32'h6c5c);
    repeat (10) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    st_is(32'h0);
    csr_r(32'h1008_0144, st);
    chk(st, 32'h0);
    for (int b = 0; b < 39; b++) begin
      d = $urandom();
      a = $urandom();
      rd_chk({gen(d), d} ^ (39'h1 << b), a, 1'b0);
      st_is(stat(3'b001, a, 1'b0, 1'b0, syn_of(b)));
      csr_w(CLR);
    end
    d = $urandom();
    p1 = $urandom();
    p2 = $urandom();
    p3 = $urandom();
    rd_chk({gen(d), d} ^ 39'h1, p1, 1'b0);
    rd_chk({gen(d), d} ^ 39'h3, p2, 1'b1);
    st_is(stat(3'b101, p2, 1'b1, 1'b0, syn_of(0) ^ syn_of(1)));
    rd_chk({gen(d), d} ^ 39'h5, p3, 1'b0);
    rd_chk({gen(d), d} ^ 39'h2, p3, 1'b0);
    st_is(stat(3'b111, p2, 1'b1, 1'b0, syn_of(0) ^ syn_of(1)));
    csr_w(32'h1fff_fe7f);
    st_is(stat(3'b111, p2, 1'b1, 1'b0, syn_of(0) ^ syn_of(1)));
    csr_w(32'h8000_0000);
    st_is(stat(3'b011, p2, 1'b1, 1'b0, syn_of(0) ^ syn_of(1)));
    csr_w(CLR);
    // cpu write with a parity fault, released before the check
    d = $urandom();
    d2 = $urandom();
    a = $urandom() & 32'h1fff_fff0;
    wr(1'b0, 1'b1, 4'hf, a, d, 1'b1);
    chk({lat, done}, {32'd0, 1'b1});
    // second parity fault on another page must not move the capture
    wr(1'b0, 1'b1, 4'hf, a + 32'h200, d2, 1'b1);
    st_is(stat(3'b000, a, 1'b0, 1'b1, 7'h07));
    w = i_mem_model.mem[a];
    chk(gen(w[31:0]) ^ w[38:32], 7'h07);
    csr_w(CLR);
    wr(1'b0, 1'b1, 4'hf, a + 4, d2, 1'b0);
    chk(i_mem_model.mem[a + 4], {gen(d2), d2});
    wr(1'b1, 1'b1, 4'hf, a + 8, d, 1'b1);
    chk({lat, done}, {32'd0, 1'b1});
    chk(i_mem_model.mem[a + 8], {gen(d), d});
    st_is(stat(3'b000, a, 1'b0, 1'b0, 7'h07));
    // masked dma pair over a slow memory, first word corrupted
    slow = 1'b1;
    i_mem_model.flip(a + 4, 39'h1 << 20);
    wr(1'b1, 1'b0, 4'h1, a + 4, d, 1'b0);
    chk({lat > 2, done}, 2'b10);
    wr(1'b1, 1'b1, 4'h2, a + 8, d, 1'b0);
    chk({lat > 2, done}, 2'b11);
    chk(i_mem_model.mem[a + 4], {gen({d2[31:8], d[7:0]}), d2[31:8], d[7:0]});
    st_is(stat(3'b001, a + 4, 1'b1, 1'b0, syn_of(20)));
    csr_w(CLR);
    slow = 1'b0;
    ecc_disable_i = 1'b1;
    rd_chk({gen(d), d} ^ 39'h3, p1, 1'b1);
    wr(1'b0, 1'b1, 4'hf, a, d, 1'b1);
    ecc_disable_i = 1'b0;
    st_is(stat(3'b000, a + 4, 1'b0, 1'b0, syn_of(20)));
    rd_chk({gen(d), d} ^ 39'h1, p1, 1'b0);
    dc_power_ok_i = 1'b0;
    repeat (5) @(posedge clock_i);
    #1 st_is(stat(3'b001, p1, 1'b0, 1'b0, syn_of(0)));
    halted_i = 1'b1;
    repeat (5) @(posedge clock_i);
    #1 dc_power_ok_i = 1'b1;
    halted_i = 1'b0;
    repeat (5) @(posedge clock_i);
    #1 st_is(32'h0);
    test_done();
  end
endmodule : tb
`default_nettype wire
